// [hw/pbp_programmer.v]
// Purpose: host-side byte programmer for a one-time programmable ROM port
// Assumes: device pins sampled synchronously, one byte command at a time
// Notes: every pin and answer output is a flip-flop; ce low freezes all state
`timescale 1ns/10ps
`include "pbp_regs.vh"

// Summary of operation
// - hold all mode select pins high always
// - write: ce low, oe high, pulse low
// - program one single byte per command
// - verify every written byte by reading back
// - upper addresses not programmed, read as ones
// - initial pulse nominal 0.20 ms wide
// - over pulse between 0.19 and 5.25 ms
// - stop after failures on two consecutive in-array commands; upper-address commands do not reset the count
module pbp_programmer #(
    parameter TW = 19,
    parameter PW_CYC = `PBP_PW_CYC,
    parameter OPW_MIN_CYC = `PBP_OPW_MIN_CYC,
    parameter OPW_MAX_CYC = `PBP_OPW_MAX_CYC,
    parameter [7:0] MAX_TRIES = `PBP_MAX_TRIES
) (
    input wire sys_clk,
    input wire rst_n,
    input wire ce,
    input wire cmd_valid,
    input wire [16:0] cmd_addr,
    input wire [7:0] cmd_data,
    output reg cmd_ready,
    output reg rsp_valid,
    output reg rsp_ok,
    output reg [7:0] rsp_data,
    output reg halted,
    input wire clear_halt,
    output reg mode_select_high,
    output reg mode_select_mid,
    output reg mode_select_low,
    output reg [16:0] byte_address_lines,
    output reg [7:0] byte_data_lines_out,
    output reg byte_data_lines_oe,
    input wire [7:0] byte_data_lines_in,
    output reg chip_enable_n,
    output reg output_enable_n,
    output reg program_pulse_strobe_n
);
    localparam [3:0] S_INIT = 4'h0;
    localparam [3:0] S_IDLE = 4'h1;
    localparam [3:0] S_SETUP = 4'h2;
    localparam [3:0] S_PULSE = 4'h3;
    localparam [3:0] S_HOLD = 4'h4;
    localparam [3:0] S_OESU = 4'h5;
    localparam [3:0] S_READ = 4'h6;
    localparam [3:0] S_FLOAT = 4'h7;

    localparam [TW-1:0] SETUP_T = `PBP_SETUP_CYC;
    localparam [TW-1:0] OE_T = `PBP_OE_CYC;
    localparam [TW-1:0] DF_T = `PBP_DF_CYC;

    reg [3:0] state_reg, state_next;
    reg [7:0] tries_reg, tries_next;
    reg over_reg, over_next;
    reg streak_reg, streak_next;
    reg tmr_load_reg, tmr_load_next;
    reg [TW-1:0] tmr_val_reg, tmr_val_next;
    reg [16:0] addr_next;
    reg [7:0] dout_next;
    reg doe_next, ce_n_next, oe_n_next, pgm_n_next;
    reg rsp_valid_next, rsp_ok_next, halted_next, ready_next;
    reg [7:0] rsp_data_next;
    wire tmr_done;

    // over pulse grows with the tries taken, clamped to the legal window
    function [TW-1:0] opw_cycles;
        input [7:0] n;
        reg [31:0] c;
        begin
            c = 32'd3 * {24'h000000, n} * PW_CYC;
            if (c > OPW_MAX_CYC)
                c = OPW_MAX_CYC;
            if (c < OPW_MIN_CYC)
                c = OPW_MIN_CYC;
            opw_cycles = c[TW-1:0];
        end
    endfunction

    pbp_pulse_timer #(.TW(TW)) u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .load(tmr_load_reg),
        .load_val(tmr_val_reg),
        .expired(tmr_done)
    );

    // sequencing of strobes, retries and answers
    always @*
    begin
        state_next = state_reg;
        tries_next = tries_reg;
        over_next = over_reg;
        streak_next = streak_reg;
        tmr_load_next = 1'b0;
        tmr_val_next = tmr_val_reg;
        addr_next = byte_address_lines;
        dout_next = byte_data_lines_out;
        doe_next = byte_data_lines_oe;
        ce_n_next = chip_enable_n;
        oe_n_next = output_enable_n;
        pgm_n_next = program_pulse_strobe_n;
        rsp_valid_next = 1'b0;
        rsp_ok_next = rsp_ok;
        rsp_data_next = rsp_data;
        halted_next = halted;
        if (clear_halt)
            halted_next = 1'b0;
        case (state_reg)
            S_INIT:
            begin
                // let the mode pins settle before the first cycle
                if (tmr_done)
                    state_next = S_IDLE;
            end
            S_IDLE:
            begin
                if (cmd_valid && cmd_ready)
                begin
                    if (cmd_addr > `PBP_ARRAY_TOP)
                    begin
                        // upper area counts as all ones
                        rsp_valid_next = 1'b1;
                        rsp_ok_next = 1'b1;
                        rsp_data_next = `PBP_ERASED;
                    end
                    else
                    begin
                        // write setup, drive address and data
                        addr_next = cmd_addr;
                        dout_next = cmd_data;
                        doe_next = 1'b1;
                        ce_n_next = 1'b0;
                        oe_n_next = 1'b1;
                        pgm_n_next = 1'b1;
                        tries_next = 8'h01;
                        over_next = 1'b0;
                        tmr_load_next = 1'b1;
                        tmr_val_next = SETUP_T;
                        state_next = S_SETUP;
                    end
                end
            end
            S_SETUP:
            begin
                if (tmr_done)
                begin
                    // program strobe low starts the write
                    pgm_n_next = 1'b0;
                    tmr_load_next = 1'b1;
                    tmr_val_next = over_reg ? opw_cycles(tries_reg) : PW_CYC[TW-1:0];
                    state_next = S_PULSE;
                end
            end
            S_PULSE:
            begin
                if (tmr_done)
                begin
                    pgm_n_next = 1'b1;
                    tmr_load_next = 1'b1;
                    tmr_val_next = SETUP_T;
                    state_next = S_HOLD;
                end
            end
            S_HOLD:
            begin
                // data is held past the pulse, then the bus is freed
                if (tmr_done)
                begin
                    doe_next = 1'b0;
                    tmr_load_next = 1'b1;
                    tmr_val_next = SETUP_T;
                    state_next = S_OESU;
                end
            end
            S_OESU:
            begin
                if (tmr_done)
                begin
                    oe_n_next = 1'b0;
                    tmr_load_next = 1'b1;
                    tmr_val_next = OE_T;
                    state_next = S_READ;
                end
            end
            S_READ:
            begin
                if (tmr_done)
                begin
                    rsp_data_next = byte_data_lines_in;
                    oe_n_next = 1'b1;
                    tmr_load_next = 1'b1;
                    tmr_val_next = DF_T;
                    state_next = S_FLOAT;
                end
            end
            S_FLOAT:
            begin
                // wait until the device has released the bus before driving it
                if (tmr_done)
                begin
                    if (rsp_data == byte_data_lines_out && !over_reg)
                    begin
                        // good read, now the over pulse
                        over_next = 1'b1;
                        doe_next = 1'b1;
                        tmr_load_next = 1'b1;
                        tmr_val_next = SETUP_T;
                        state_next = S_SETUP;
                    end
                    else if (rsp_data != byte_data_lines_out && !over_reg &&
                        tries_reg < MAX_TRIES)
                    begin
                        tries_next = tries_reg + 8'h01;
                        doe_next = 1'b1;
                        tmr_load_next = 1'b1;
                        tmr_val_next = SETUP_T;
                        state_next = S_SETUP;
                    end
                    else
                    begin
                        rsp_valid_next = 1'b1;
                        rsp_ok_next = (rsp_data == byte_data_lines_out);
                        ce_n_next = 1'b1;
                        state_next = S_IDLE;
                        // two failing in-array commands in a row halt; upper-address commands leave the streak alone
                        if (rsp_data != byte_data_lines_out)
                        begin
                            if (streak_reg)
                                halted_next = 1'b1;
                            streak_next = 1'b1;
                        end
                        else
                            streak_next = 1'b0;
                    end
                end
            end
            default:
            begin
                state_next = S_IDLE;
                ce_n_next = 1'b1;
                oe_n_next = 1'b1;
                pgm_n_next = 1'b1;
                doe_next = 1'b0;
            end
        endcase
        // halted blocks new commands; the set above wins over clear_halt
        ready_next = (state_next == S_IDLE) && !halted_next && !(cmd_valid && cmd_ready);
    end

    // state and pin registers; ce low freezes everything
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= S_INIT;
            tries_reg <= 8'h00;
            over_reg <= 1'b0;
            streak_reg <= 1'b0;
            tmr_load_reg <= 1'b1;
            tmr_val_reg <= SETUP_T;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_ok <= 1'b0;
            rsp_data <= 8'h00;
            halted <= 1'b0;
            mode_select_high <= `PBP_MODE_RST;
            mode_select_mid <= `PBP_MODE_RST;
            mode_select_low <= `PBP_MODE_RST;
            byte_address_lines <= 17'h00000;
            byte_data_lines_out <= 8'h00;
            byte_data_lines_oe <= 1'b0;
            chip_enable_n <= 1'b1;
            output_enable_n <= 1'b1;
            program_pulse_strobe_n <= 1'b1;
        end
        else if (ce)
        begin
            state_reg <= state_next;
            tries_reg <= tries_next;
            over_reg <= over_next;
            streak_reg <= streak_next;
            tmr_load_reg <= tmr_load_next;
            tmr_val_reg <= tmr_val_next;
            cmd_ready <= ready_next;
            rsp_valid <= rsp_valid_next;
            rsp_ok <= rsp_ok_next;
            rsp_data <= rsp_data_next;
            halted <= halted_next;
            byte_address_lines <= addr_next;
            byte_data_lines_out <= dout_next;
            byte_data_lines_oe <= doe_next;
            chip_enable_n <= ce_n_next;
            output_enable_n <= oe_n_next;
            program_pulse_strobe_n <= pgm_n_next;
        end
    end
endmodule

// [include/pbp_regs.vh]
// Purpose: shared constants of the byte programming controller
// Assumes: sys_clk at 50 MHz
// Notes: times are in ns, cycle counts are derived from them
`ifndef PBP_REGS_VH
`define PBP_REGS_VH

`define PBP_CLK_MHZ 50
// least setup and hold times (address, data, output enable, chip enable)
`define PBP_T_SETUP_NS 2000
// output enable to data valid, longest
`define PBP_T_OE_NS 150
// output disable time, longest
`define PBP_T_DF_NS 130
// initial program pulse, nominal and limits
`define PBP_T_PW_NS 200000
`define PBP_T_PW_MIN_NS 190000
`define PBP_T_PW_MAX_NS 210000
// over-programming pulse limits
`define PBP_T_OPW_MIN_NS 190000
`define PBP_T_OPW_MAX_NS 5250000

// least times round up, waits for a longest time also round up so data is settled
`define PBP_SETUP_CYC ((`PBP_T_SETUP_NS * `PBP_CLK_MHZ + 999) / 1000)
`define PBP_OE_CYC ((`PBP_T_OE_NS * `PBP_CLK_MHZ + 999) / 1000)
`define PBP_DF_CYC ((`PBP_T_DF_NS * `PBP_CLK_MHZ + 999) / 1000)
`define PBP_PW_CYC ((`PBP_T_PW_NS * `PBP_CLK_MHZ) / 1000)
`define PBP_OPW_MIN_CYC ((`PBP_T_OPW_MIN_NS * `PBP_CLK_MHZ + 999) / 1000)
`define PBP_OPW_MAX_CYC ((`PBP_T_OPW_MAX_NS * `PBP_CLK_MHZ) / 1000)

// array geometry
`define PBP_ADDR_W 17
`define PBP_ARRAY_TOP 17'h07fff
`define PBP_ERASED 8'hff
// retry limit of the initial pulse loop
`define PBP_MAX_TRIES 8'h19
// mode select pins are held high from reset onward
`define PBP_MODE_RST 1'b1

`endif

// [hw/pbp_pulse_timer.v]
// Purpose: down counter that times setup, pulse and read windows
// Assumes: load is a one-cycle request, ce freezes the count
// Notes: expired stays low in the load cycle so a stale zero is never seen
`timescale 1ns/10ps
module pbp_pulse_timer #(
    parameter TW = 19
) (
    input wire sys_clk,
    input wire rst_n,
    input wire ce,
    input wire load,
    input wire [TW-1:0] load_val,
    output wire expired
);
    reg [TW-1:0] count_reg;

    // count down to zero and rest there
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            count_reg <= {TW{1'b0}};
        else if (ce)
        begin
            if (load)
                count_reg <= load_val;
            else if (count_reg != {TW{1'b0}})
                count_reg <= count_reg - {{(TW-1){1'b0}}, 1'b1};
        end
    end

    assign expired = (count_reg == {TW{1'b0}}) && !load;
endmodule

// [testbench/pbp_programmer_monitor.sv]
// Purpose: port checker of the byte programmer
// Assumes: ce stays high while a pulse or verify runs
// Notes: pulse widths are counted in enabled cycles
`timescale 1ns/10ps
module pbp_programmer_monitor #(
    parameter PW_CYC = 20,
    parameter OPW_MIN_CYC = 10,
    parameter OPW_MAX_CYC = 200
) (
    input wire sys_clk,
    input wire rst_n,
    input wire ce,
    input wire cmd_valid,
    input wire [16:0] cmd_addr,
    input wire cmd_ready,
    input wire rsp_valid,
    input wire rsp_ok,
    input wire [7:0] rsp_data,
    input wire halted,
    input wire mode_select_high,
    input wire mode_select_mid,
    input wire mode_select_low,
    input wire [16:0] byte_address_lines,
    input wire byte_data_lines_oe,
    input wire chip_enable_n,
    input wire output_enable_n,
    input wire program_pulse_strobe_n
);
    reg [19:0] low_cnt_reg;
    reg first_reg;
    wire take = ce && cmd_valid && cmd_ready;
    wire pulse_end = program_pulse_strobe_n && (low_cnt_reg != 20'h0);
    // low time of the pulse, and whether it is the first of a command
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_cnt_reg <= 20'h0;
            first_reg <= 1'b0;
        end
        else
        begin
            if (program_pulse_strobe_n)
                low_cnt_reg <= 20'h0;
            else if (ce)
                low_cnt_reg <= low_cnt_reg + 20'h1;
            if (take)
                first_reg <= 1'b1;
            else if (pulse_end)
                first_reg <= 1'b0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_mode_pins_high: assert property (mode_select_high && mode_select_mid && mode_select_low)
        else $error("mode pins not all high");
    a_write_levels: assert property (!program_pulse_strobe_n |-> !chip_enable_n && output_enable_n)
        else $error("pulse outside write levels");
    a_verify_levels: assert property (!output_enable_n |-> program_pulse_strobe_n && !chip_enable_n
        && !byte_data_lines_oe)
        else $error("bad verify levels");
    a_drive_when_off: assert property (byte_data_lines_oe |-> output_enable_n)
        else $error("host drives while output enabled");
    a_addr_stable: assert property (!chip_enable_n && $past(!chip_enable_n)
        |-> $stable(byte_address_lines))
        else $error("address moved in a cycle");
    a_addr_range: assert property (!chip_enable_n |-> byte_address_lines <= 17'h07fff)
        else $error("device selected above array");
    a_upper_answer: assert property (take && cmd_addr > 17'h07fff
        |=> rsp_valid && rsp_ok && rsp_data == 8'hff && chip_enable_n)
        else $error("upper address answer wrong");
    a_init_width: assert property (pulse_end && first_reg |-> low_cnt_reg == PW_CYC + 2)
        else $error("initial pulse width wrong");
    a_pulse_range: assert property (pulse_end |-> low_cnt_reg >= OPW_MIN_CYC
        && low_cnt_reg <= OPW_MAX_CYC + 2)
        else $error("pulse width out of range");
    a_verify_follows: assert property ($rose(program_pulse_strobe_n)
        |-> ##[1:400] !output_enable_n)
        else $error("no verify after pulse");
    a_halt_blocks: assert property (halted |-> !cmd_ready)
        else $error("command accepted while halted");
    c_pulse: cover property ($fell(program_pulse_strobe_n));
    c_upper: cover property (take && cmd_addr > 17'h07fff);
    c_fail: cover property (rsp_valid && !rsp_ok);
    c_halt: cover property ($rose(halted));
endmodule
bind pbp_programmer pbp_programmer_monitor #(.PW_CYC(PW_CYC), .OPW_MIN_CYC(OPW_MIN_CYC),
    .OPW_MAX_CYC(OPW_MAX_CYC)) u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_ok(rsp_ok), .rsp_data(rsp_data), .halted(halted), .mode_select_high(mode_select_high),
    .mode_select_mid(mode_select_mid), .mode_select_low(mode_select_low),
    .byte_address_lines(byte_address_lines), .byte_data_lines_oe(byte_data_lines_oe),
    .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
    .program_pulse_strobe_n(program_pulse_strobe_n));

// [testbench/pbp_prom_model.sv]
// Purpose: behavioural one-time programmable byte array on the pins
// Assumes: strobes are active low, data lines have no pull
// Notes: also resolves the shared data wire from both enables
`timescale 1ns/10ps
module pbp_prom_model (
    input wire mode_select_high,
    input wire mode_select_mid,
    input wire mode_select_low,
    input wire chip_enable_n,
    input wire output_enable_n,
    input wire program_pulse_strobe_n,
    input wire [16:0] byte_address_lines,
    input wire [7:0] host_data,
    input wire host_oe,
    output wire [7:0] pin_data,
    output reg [31:0] pulse_count,
    output reg collide
);
    reg [7:0] mem [0:32767];
    reg [7:0] held;
    reg dev_on;
    integer i;
    wire mode_ok = mode_select_high && mode_select_mid && mode_select_low;
    wire in_arr = byte_address_lines <= 17'h07fff;
    wire [14:0] idx = byte_address_lines[14:0];
    // verify read, only inside the array
    wire rd_now = mode_ok && !chip_enable_n && !output_enable_n && program_pulse_strobe_n && in_arr;
    initial
    begin
        pulse_count = 0;
        collide = 1'b0;
        held = 8'h00;
        dev_on = 1'b0;
        for (i = 0; i < 32768; i = i + 1)
            mem[i] = 8'hff;
    end
    // output appears and releases only after the access delays
    always @(rd_now)
        dev_on <= #(rd_now ? 150 : 130) rd_now;
    // write at pulse end; cells can only lose ones
    always @(posedge program_pulse_strobe_n)
        if (mode_ok && !chip_enable_n && output_enable_n)
        begin
            pulse_count = pulse_count + 1;
            if (in_arr)
                mem[idx] = mem[idx] & pin_data;
        end
    // a released wire shows the inverse of its last level
    always @*
        if (host_oe)
            held = host_data;
        else if (dev_on)
            held = mem[idx];
    assign pin_data = (host_oe || dev_on) ? held : ~held;
    always @*
        if (host_oe && dev_on)
            collide = 1'b1;
endmodule

// [testbench/pbp_programmer_tb_top.sv]
// Purpose: self-checking bench of the byte programmer
// Assumes: short pulse parameters, three tries per byte
// Notes: inputs change at the falling edge only
`timescale 1ns/10ps
module pbp_programmer_tb_top;
    reg sys_clk, rst_n, ce, cmd_valid, clear_halt;
    reg [16:0] cmd_addr;
    reg [7:0] cmd_data;
    wire cmd_ready, rsp_valid, rsp_ok, halted, msh, msm, msl, d_oe, ce_n, oe_n, pgm_n, collide;
    wire [7:0] rsp_data, d_out, d_in;
    wire [16:0] addr;
    wire [31:0] pulse_count;
    integer errors, num_checks, cyc;
    pbp_programmer #(.PW_CYC(20), .OPW_MIN_CYC(10), .OPW_MAX_CYC(200), .MAX_TRIES(8'h03))
    pbp_programmer_inst (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_ok(rsp_ok), .rsp_data(rsp_data), .halted(halted), .clear_halt(clear_halt),
        .mode_select_high(msh), .mode_select_mid(msm), .mode_select_low(msl),
        .byte_address_lines(addr), .byte_data_lines_out(d_out), .byte_data_lines_oe(d_oe),
        .byte_data_lines_in(d_in), .chip_enable_n(ce_n), .output_enable_n(oe_n),
        .program_pulse_strobe_n(pgm_n));
    pbp_prom_model pbp_prom_model_inst (.mode_select_high(msh), .mode_select_mid(msm),
        .mode_select_low(msl), .chip_enable_n(ce_n), .output_enable_n(oe_n),
        .program_pulse_strobe_n(pgm_n), .byte_address_lines(addr), .host_data(d_out),
        .host_oe(d_oe), .pin_data(d_in), .pulse_count(pulse_count), .collide(collide));
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task check(input [8*10-1:0] what, input [31:0] seen, input [31:0] exp);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("[ERR] %0s expected %0h seen %0h", what, exp, seen);
        end
    end
    endtask
    task stop_test;
    begin
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    // one byte command; waits are bounded so a hang shows as a mismatch
    task do_cmd(input [16:0] a, input [7:0] d, input ok, input [7:0] rd, input [31:0] np);
        integer n;
        reg [31:0] p0;
    begin
        p0 = pulse_count;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 2000)
        begin
            @(negedge sys_clk);
            n = n + 1;
        end
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 9000)
        begin
            @(negedge sys_clk);
            n = n + 1;
        end
        check("rsp_valid", rsp_valid, 1'b1);
        check("rsp_ok", rsp_ok, ok);
        check("rsp_data", rsp_data, rd);
        check("pulses", pulse_count - p0, np);
        @(negedge sys_clk);
    end
    endtask
    task t_idle;
        integer n;
    begin
        check("idle_pins", {msh, msm, msl, ce_n, oe_n, pgm_n, d_oe}, 7'h7e);
        check("ready_rst", cmd_ready, 1'b0);
        rst_n = 1'b1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 500)
        begin
            @(negedge sys_clk);
            n = n + 1;
        end
        check("ready_up", cmd_ready, 1'b1);
        $display("test idle done");
    end
    endtask
    task t_write;
    begin
        do_cmd(17'h00000, 8'h5a, 1'b1, 8'h5a, 2);
        check("mem_lo", pbp_prom_model_inst.mem[0], 8'h5a);
        do_cmd(17'h07fff, 8'h00, 1'b1, 8'h00, 2);
        check("mem_top", pbp_prom_model_inst.mem[32767], 8'h00);
        $display("test write done");
    end
    endtask
    task t_upper;
    begin
        do_cmd(17'h08000, 8'h12, 1'b1, 8'hff, 0);
        do_cmd(17'h1ffff, 8'h34, 1'b1, 8'hff, 0);
        $display("test upper done");
    end
    endtask
    // ce low must hold off a pending take; the same command goes through once ce returns
    task t_freeze;
    begin
        ce = 1'b0;
        cmd_addr = 17'h08000;
        cmd_data = 8'h77;
        cmd_valid = 1'b1;
        repeat (20) @(negedge sys_clk);
        check("frz_rdy", cmd_ready, 1'b1);
        check("frz_rsp", rsp_valid, 1'b0);
        cmd_valid = 1'b0;
        ce = 1'b1;
        do_cmd(17'h08000, 8'h77, 1'b1, 8'hff, 0);
        $display("test freeze done");
    end
    endtask
    task t_halt;
    begin
        do_cmd(17'h00000, 8'hf0, 1'b0, 8'h50, 3);
        check("halt_one", halted, 1'b0);
        do_cmd(17'h00000, 8'ha5, 1'b0, 8'h00, 3);
        check("halt_two", halted, 1'b1);
        cmd_valid = 1'b1;
        repeat (50) @(negedge sys_clk);
        check("refused", cmd_ready, 1'b0);
        clear_halt = 1'b1;
        @(negedge sys_clk);
        clear_halt = 1'b0;
        do_cmd(17'h00001, 8'h3c, 1'b1, 8'h3c, 2);
        check("mem_next", pbp_prom_model_inst.mem[1], 8'h3c);
        $display("test halt done");
    end
    endtask
    // cycle ceiling about four times the expected run
    always @(posedge sys_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            errors = errors + 1;
            stop_test;
        end
    end
    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        cmd_valid = 1'b0;
        clear_halt = 1'b0;
        cmd_addr = 17'h00000;
        cmd_data = 8'h00;
        errors = 0;
        num_checks = 0;
        cyc = 0;
        repeat (10) @(negedge sys_clk);
        t_idle;
        t_write;
        t_upper;
        t_freeze;
        t_halt;
        check("collide", collide, 1'b0);
        stop_test;
    end
endmodule
